// ### pllc_core.sv
// Digital model of the loop control wrapper with dynamic delay and status registers
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pllc_params.svh"

// Overview of operation
// [RQ1] Reference taken from pin or routing
// [RQ2] Feedback from internal, clock net or user
// [RQ3] Reset input high clears input divider
// [RQ4] Lock output high once loop locked
// [RQ5] Primary clock carries no phase shift
// [RQ6] Shifted clock has phase/duty as configured
// [RQ7] Third clock passes a secondary divider
// [RQ8] Select high dynamic pins, low fuses
// [RQ9] Zero input high forces zero delay
// [RQ10] Lag high, lead low; 3-bit magnitude
// [RQ11] Zero status output shows applied zero
// [RQ12] Lag and value outputs show applied delay
// [RQ13] Static mode reports fuse settings
// [RQ14] Lock low during reset until reacquired
module pllc_core #(
  parameter int IN_DIV = 1,
  parameter int SEC_DIV = 2,
  parameter int PW = 12,
  parameter logic FUSE_ZERO = 1'b1,
  parameter logic FUSE_LAG = 1'b1,
  parameter logic [2:0] FUSE_VALUE = 3'h0,
  parameter logic FUSE_DUTY_STRETCH = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ref_clk_pin_i,
  input wire logic ref_clk_route_i,
  input wire logic user_fb_clk_i,
  input wire logic divider_rst_i,
  input wire logic delay_source_sel_i,
  input wire logic delay_zero_in_i,
  input wire logic delay_lag_in_i,
  input wire logic [2:0] delay_value_in_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  output logic primary_clk_out_o,
  output logic shifted_clk_out_o,
  output logic divided_clk_out_o,
  output logic lock_o,
  output logic delay_zero_out_o,
  output logic delay_lag_out_o,
  output logic [2:0] delay_value_out_o
);
  import pllc_pkg::*;

  // ****************************************************************
  // Control registers and reference / feedback selection
  // ****************************************************************
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [2:0] status;
  logic [2:0] next_status;
  logic [2:0] mask;
  logic [2:0] next_mask;
  logic [7:0] next_rdata;
  pllc_fb_src_type fb_src;
  logic ref_clk;
  logic ref_q;
  logic fb_clk;
  logic fb_q;
  logic ref_rise;
  logic fb_rise;
  logic raw_primary;
  logic net_primary;

  always_comb
  begin
    fb_src = pllc_fb_src_type'(ctrl[`PLLC_CTRL_FB_HI:`PLLC_CTRL_FB_LO]);
    ref_clk = ctrl[`PLLC_CTRL_REF_SEL] ? ref_clk_route_i : ref_clk_pin_i; // [RQ1]
    unique case (fb_src) // [RQ2]
      PLLC_FB_INTERNAL: fb_clk = raw_primary;
      PLLC_FB_NET: fb_clk = net_primary;
      PLLC_FB_USER: fb_clk = user_fb_clk_i;
      PLLC_FB_SPARE: fb_clk = raw_primary;
    endcase
    ref_rise = ref_clk & ~ref_q;
    fb_rise = fb_clk & ~fb_q;
  end

  // ****************************************************************
  // Input divider and period measurement
  // ****************************************************************
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic div_edge;
  logic [PW-1:0] meas;
  logic [PW-1:0] next_meas;
  logic [PW-1:0] period;
  logic [PW-1:0] next_period;
  logic [PW-1:0] ph;
  logic [PW-1:0] next_ph;
  logic [PW-1:0] since_ref;
  logic [PW-1:0] next_since_ref;
  logic [2:0] good_cnt;
  logic [2:0] next_good_cnt;
  logic period_ok;
  logic fb_ok;
  logic next_fb_ok;
  pllc_lock_state_type lock_state;
  pllc_lock_state_type next_lock_state;

  always_comb
  begin
    div_edge = 1'b0;
    next_div_cnt = div_cnt;
    if (ref_rise)
    begin
      if (div_cnt >= 8'(IN_DIV - 1))
      begin
        next_div_cnt = 8'h00;
        div_edge = 1'b1;
      end
      else
      begin
        next_div_cnt = div_cnt + 8'h01;
      end
    end
    if (divider_rst_i)
    begin
      next_div_cnt = 8'h00; // [RQ3]
      div_edge = 1'b0;
    end
    next_meas = div_edge ? {{(PW-1){1'b0}}, 1'b1} : meas + {{(PW-1){1'b0}}, 1'b1};
    next_period = div_edge ? meas : period;
    period_ok = (meas == period) || (meas == period + {{(PW-1){1'b0}}, 1'b1})
      || (meas + {{(PW-1){1'b0}}, 1'b1} == period);
    // Output phase restarts on each divided reference edge, so no shift
    if (div_edge || (ph + {{(PW-1){1'b0}}, 1'b1} >= period))
      next_ph = '0; // [RQ5]
    else
      next_ph = ph + {{(PW-1){1'b0}}, 1'b1};
    next_since_ref = div_edge ? '0 : since_ref + {{(PW-1){1'b0}}, 1'b1};
    next_fb_ok = fb_ok;
    if (div_edge)
      next_fb_ok = 1'b0;
    if (fb_rise && (since_ref <= PW'(`PLLC_LOCK_TOL)))
      next_fb_ok = 1'b1;
  end

  // ****************************************************************
  // Lock detection
  // ****************************************************************
  always_comb
  begin
    next_lock_state = lock_state;
    next_good_cnt = good_cnt;
    unique case (lock_state)
      PLLC_UNLOCKED:
      begin
        next_good_cnt = 3'h0;
        if (div_edge)
          next_lock_state = PLLC_ACQUIRE;
      end
      PLLC_ACQUIRE:
      begin
        if (div_edge)
        begin
          if (period_ok && fb_ok)
            next_good_cnt = good_cnt + 3'h1;
          else
            next_good_cnt = 3'h0;
          if (period_ok && fb_ok && (good_cnt >= 3'(`PLLC_LOCK_COUNT - 1)))
            next_lock_state = PLLC_LOCKED; // [RQ4]
        end
      end
      PLLC_LOCKED:
      begin
        if (div_edge && !period_ok)
          next_lock_state = PLLC_UNLOCKED;
      end
    endcase
    if (divider_rst_i)
    begin
      next_lock_state = PLLC_UNLOCKED; // [RQ14]
      next_good_cnt = 3'h0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      ref_q <= 1'b0;
      fb_q <= 1'b0;
      div_cnt <= 8'h00;
      meas <= '0;
      period <= '0;
      ph <= '0;
      since_ref <= '0;
      fb_ok <= 1'b0;
      good_cnt <= 3'h0;
      lock_state <= PLLC_UNLOCKED;
    end
    else
    begin
      ref_q <= ref_clk;
      fb_q <= fb_clk;
      div_cnt <= next_div_cnt;
      meas <= next_meas;
      period <= next_period;
      ph <= next_ph;
      since_ref <= next_since_ref;
      fb_ok <= next_fb_ok;
      good_cnt <= next_good_cnt;
      lock_state <= next_lock_state;
    end
  end

  assign raw_primary = (ph < (period >> 1));
  assign lock_o = (lock_state == PLLC_LOCKED); // [RQ4] [RQ14]

  // ****************************************************************
  // Delay selection: dynamic pins or fuses
  // ****************************************************************
  logic app_zero;
  logic app_lag;
  logic [2:0] app_value;
  logic [3:0] tap;

  always_comb
  begin
    if (delay_source_sel_i) // [RQ8]
    begin
      app_zero = delay_zero_in_i;
      app_lag = delay_lag_in_i;
      app_value = delay_value_in_i;
    end
    else
    begin
      app_zero = FUSE_ZERO; // [RQ13]
      app_lag = FUSE_LAG;
      app_value = FUSE_VALUE;
    end
    // Lag reads an older tap, lead a younger one
    if (app_zero)
      tap = 4'(`PLLC_DELAY_BASE); // [RQ9]
    else if (app_lag)
      tap = 4'(`PLLC_DELAY_BASE) + {1'b0, app_value}; // [RQ10]
    else
      tap = 4'(`PLLC_DELAY_BASE) - {1'b0, app_value};
  end

  // ****************************************************************
  // Output clocks
  // ****************************************************************
  logic base_clk;
  logic tap_clk;
  logic tap_clk_q;
  logic [7:0] sec_cnt;
  logic [7:0] next_sec_cnt;
  logic next_divided;
  logic next_shifted;

  pllc_tap_delay #(
    .DEPTH(`PLLC_DELAY_DEPTH),
    .AW(4)
  ) u_delay (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i(raw_primary),
    .base_i(4'(`PLLC_DELAY_BASE)),
    .tap_i(tap),
    .base_o(base_clk),
    .tap_o(tap_clk)
  );

  always_comb
  begin
    // Duty stretch widens the high phase by one cycle
    next_shifted = FUSE_DUTY_STRETCH ? (tap_clk | tap_clk_q) : tap_clk; // [RQ6]
    next_sec_cnt = sec_cnt;
    next_divided = divided_clk_out_o;
    if (base_clk && !primary_clk_out_o)
    begin
      if (sec_cnt >= 8'(SEC_DIV - 1))
      begin
        next_sec_cnt = 8'h00;
        next_divided = ~divided_clk_out_o; // [RQ7]
      end
      else
      begin
        next_sec_cnt = sec_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      tap_clk_q <= 1'b0;
      primary_clk_out_o <= 1'b0;
      shifted_clk_out_o <= 1'b0;
      divided_clk_out_o <= 1'b0;
      sec_cnt <= 8'h00;
      net_primary <= 1'b0;
      delay_zero_out_o <= 1'b0;
      delay_lag_out_o <= 1'b0;
      delay_value_out_o <= 3'h0;
    end
    else
    begin
      tap_clk_q <= tap_clk;
      primary_clk_out_o <= base_clk; // [RQ5]
      shifted_clk_out_o <= next_shifted;
      divided_clk_out_o <= next_divided;
      sec_cnt <= next_sec_cnt;
      net_primary <= base_clk;
      delay_zero_out_o <= app_zero; // [RQ11]
      delay_lag_out_o <= app_lag; // [RQ12]
      delay_value_out_o <= app_value;
    end
  end

  // ****************************************************************
  // Register port and interrupt
  // ****************************************************************
  logic lock_q;
  logic [4:0] dly_q;
  logic [2:0] events;

  always_comb
  begin
    events = 3'h0;
    events[`PLLC_ST_LOCK_GAINED] = lock_o & ~lock_q;
    events[`PLLC_ST_LOCK_LOST] = ~lock_o & lock_q;
    events[`PLLC_ST_DELAY_CHG] = (dly_q != {app_zero, app_lag, app_value});
    next_ctrl = ctrl;
    next_mask = mask;
    next_status = status;
    if (wr_i && (addr_i == `PLLC_ADDR_CTRL))
      next_ctrl = wdata_i;
    if (wr_i && (addr_i == `PLLC_ADDR_MASK))
      next_mask = wdata_i[2:0];
    if (wr_i && (addr_i == `PLLC_ADDR_STATUS))
      next_status = status & ~wdata_i[2:0];
    // A new event wins over a clear in the same cycle
    next_status = next_status | events;
    next_rdata = 8'h00;
    if (rd_i)
    begin
      unique case (addr_i)
        `PLLC_ADDR_CTRL: next_rdata = {5'h00, ctrl[2:0]};
        `PLLC_ADDR_STATUS: next_rdata = {lock_o, 4'h0, status};
        `PLLC_ADDR_MASK: next_rdata = {5'h00, mask};
        `PLLC_ADDR_DELAY: next_rdata = {2'h0, delay_source_sel_i, app_zero, app_lag, app_value};
        `PLLC_ADDR_PERIOD: next_rdata = period[7:0];
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      ctrl <= `PLLC_CTRL_RESET;
      mask <= 3'h0;
      status <= 3'h0;
      rdata_o <= 8'h00;
      lock_q <= 1'b0;
      // Start from the fuse settings so leaving reset with fuses selected raises no delay change
      dly_q <= {FUSE_ZERO, FUSE_LAG, FUSE_VALUE};
    end
    else
    begin
      ctrl <= next_ctrl;
      mask <= next_mask;
      status <= next_status;
      rdata_o <= next_rdata;
      lock_q <= lock_o;
      dly_q <= {app_zero, app_lag, app_value};
    end
  end

  assign irq_o = |(status & mask);

endmodule
`default_nettype wire

// ### pllc_params.svh
// Constants for the clock control wrapper: offsets, fields, reset values, counts
`ifndef PLLC_PARAMS_SVH
`define PLLC_PARAMS_SVH

// ****************************************************************
// Register offsets (4-bit address)
// ****************************************************************
`define PLLC_ADDR_CTRL 4'h0
`define PLLC_ADDR_STATUS 4'h1
`define PLLC_ADDR_MASK 4'h2
`define PLLC_ADDR_DELAY 4'h3
`define PLLC_ADDR_PERIOD 4'h4

// ****************************************************************
// Field positions
// ****************************************************************
`define PLLC_CTRL_REF_SEL 0
`define PLLC_CTRL_FB_LO 1
`define PLLC_CTRL_FB_HI 2
`define PLLC_ST_LOCK_GAINED 0
`define PLLC_ST_LOCK_LOST 1
`define PLLC_ST_DELAY_CHG 2
`define PLLC_ST_LOCK_NOW 7
`define PLLC_DLY_VALUE_LO 0
`define PLLC_DLY_VALUE_HI 2
`define PLLC_DLY_LAG 3
`define PLLC_DLY_ZERO 4
`define PLLC_DLY_DYNAMIC 5

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define PLLC_CTRL_RESET 8'h00
`define PLLC_MASK_RESET 8'h00
`define PLLC_EVENT_BITS 3
`define PLLC_LOCK_COUNT 4
`define PLLC_LOCK_TOL 2
`define PLLC_DELAY_BASE 8
`define PLLC_DELAY_DEPTH 16

`endif

// ### pllc_pkg.sv
// Types shared by the clock control wrapper
package pllc_pkg;

  typedef enum logic [1:0]
  {
    PLLC_FB_INTERNAL = 2'h0,
    PLLC_FB_NET = 2'h1,
    PLLC_FB_USER = 2'h2,
    PLLC_FB_SPARE = 2'h3
  } pllc_fb_src_type;

  typedef enum logic [2:0]
  {
    PLLC_UNLOCKED = 3'b001,
    PLLC_ACQUIRE = 3'b010,
    PLLC_LOCKED = 3'b100
  } pllc_lock_state_type;

endpackage

// ### pllc_tap_delay.sv
// Tapped delay line with registered base and selected taps
`timescale 1ns/1ps
`default_nettype none
module pllc_tap_delay #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  input wire logic [AW-1:0] base_i,
  input wire logic [AW-1:0] tap_i,
  output logic base_o,
  output logic tap_o
);

  logic [DEPTH-1:0] line;
  logic [DEPTH-1:0] next_line;
  logic next_base;
  logic next_tap;

  always_comb
  begin
    next_line = {line[DEPTH-2:0], d_i};
    next_base = line[base_i];
    next_tap = line[tap_i];
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      line <= '0;
      base_o <= 1'b0;
      tap_o <= 1'b0;
    end
    else
    begin
      line <= next_line;
      base_o <= next_base;
      tap_o <= next_tap;
    end
  end

endmodule
`default_nettype wire

// ### pllc_core_properties.sv
// Port level assertions for the clock control wrapper
`timescale 1ns/1ps
`default_nettype none
module pllc_core_properties #(
  parameter logic FUSE_ZERO = 1'b1,
  parameter logic FUSE_LAG = 1'b1,
  parameter logic [2:0] FUSE_VALUE = 3'h0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic divider_rst_i,
  input wire logic delay_source_sel_i,
  input wire logic delay_zero_in_i,
  input wire logic delay_lag_in_i,
  input wire logic [2:0] delay_value_in_i,
  input wire logic [3:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic lock_o,
  input wire logic delay_zero_out_o,
  input wire logic delay_lag_out_o,
  input wire logic [2:0] delay_value_out_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ****************************************************************
  // Sequences
  // ****************************************************************
  sequence live_s;
    rst_n_i && $past(rst_n_i);
  endsequence
  sequence div_release_s;
    $past(divider_rst_i) && !divider_rst_i;
  endsequence
  // ****************************************************************
  // Properties
  // ****************************************************************
  dyn_zero_echo_a: assert property (live_s ##0 (delay_source_sel_i && delay_zero_in_i)
    |=> delay_zero_out_o) else $error("zero status not applied");
  dyn_lag_echo_a: assert property (live_s ##0 (delay_source_sel_i && !delay_zero_in_i)
    |=> !delay_zero_out_o && delay_lag_out_o == $past(delay_lag_in_i)) else $error("lag echo wrong");
  dyn_value_echo_a: assert property (live_s ##0 (delay_source_sel_i && !delay_zero_in_i)
    |=> delay_value_out_o == $past(delay_value_in_i)) else $error("value echo wrong");
  static_fuse_a: assert property (live_s ##0 !delay_source_sel_i |=> delay_zero_out_o == FUSE_ZERO
    && delay_lag_out_o == FUSE_LAG && delay_value_out_o == FUSE_VALUE) else $error("fuse echo wrong");
  lock_drop_a: assert property (divider_rst_i |=> !lock_o) else $error("lock kept in reset");
  lock_regain_a: assert property (div_release_s |-> !lock_o [*4]) else $error("lock too early");
  read_idle_a: assert property (live_s ##0 !rd_i |=> rdata_o == 8'h00) else $error("rdata not idle");
  unmapped_read_a: assert property (rd_i && addr_i > 4'h4 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  lock_status_a: assert property (live_s ##0 (rd_i && addr_i == 4'h1)
    |=> rdata_o[7] == $past(lock_o)) else $error("lock bit read wrong");
endmodule
bind pllc_core pllc_core_properties #(.FUSE_ZERO(FUSE_ZERO), .FUSE_LAG(FUSE_LAG),
  .FUSE_VALUE(FUSE_VALUE)) chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .divider_rst_i(divider_rst_i), .delay_source_sel_i(delay_source_sel_i),
  .delay_zero_in_i(delay_zero_in_i), .delay_lag_in_i(delay_lag_in_i),
  .delay_value_in_i(delay_value_in_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .lock_o(lock_o), .delay_zero_out_o(delay_zero_out_o), .delay_lag_out_o(delay_lag_out_o),
  .delay_value_out_o(delay_value_out_o));
`default_nettype wire

// ### pllc_fabric.sv
// Model of the user fabric: reference clocks, feedback clock, delay controls, divider reset
`timescale 1ns/1ps
`default_nettype none
module pllc_fabric #(
  parameter int REF_HALF = 4
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [6:0] want_i,
  output logic ref_pin_o,
  output logic ref_route_o,
  output logic user_fb_o,
  output logic divider_rst_o,
  output logic sel_o,
  output logic zero_o,
  output logic lag_o,
  output logic [2:0] value_o
);
  int cnt;
  int cnt_route;
  // ****************************************************************
  // Fabric registers
  // ****************************************************************
  always_ff @(posedge clock_i)
  begin
    cnt <= (!rst_n_i || cnt == REF_HALF - 1) ? 0 : cnt + 1;
    cnt_route <= (!rst_n_i || cnt_route == 2 * REF_HALF - 1) ? 0 : cnt_route + 1;
    // Routed reference runs at half the pin rate so the select shows in the period
    if (!rst_n_i)
      ref_route_o <= 1'b0;
    else if (cnt_route == 2 * REF_HALF - 1)
      ref_route_o <= !ref_route_o;
    if (rst_n_i && cnt == REF_HALF - 1)
      ref_pin_o <= !ref_pin_o;
    else if (!rst_n_i)
      ref_pin_o <= 1'b0;
    user_fb_o <= ref_pin_o;
    {divider_rst_o, sel_o, zero_o, lag_o, value_o} <= rst_n_i ? want_i : 7'h00;
  end
endmodule
`default_nettype wire

// ### pllc_core_test.sv
// Self-checking testbench for the clock control wrapper
`timescale 1ns/1ps
`default_nettype none
module pllc_core_test;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [6:0] want = 7'h00;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o, d;
  logic irq_o, lock_o, zo, lo, rp, rr, uf, dr, sl, zi, li;
  logic po, so, ko;
  logic [2:0] vo, vi;
  int n_mismatch = 0;
  int check_count = 0;
  // sel, zero, lag, value | expected zero, lag, value
  localparam logic [10:0] ROWS [6] = '{11'b1_0_1_011_0_1_011, 11'b1_0_0_101_0_0_101,
    11'b1_0_1_111_0_1_111, 11'b1_0_0_000_0_0_000, 11'b1_1_1_110_1_0_000, 11'b0_0_0_101_1_1_000};
  pllc_fabric fab (.clock_i(clock_i), .rst_n_i(rst_n_i), .want_i(want), .ref_pin_o(rp),
    .ref_route_o(rr), .user_fb_o(uf), .divider_rst_o(dr), .sel_o(sl), .zero_o(zi), .lag_o(li),
    .value_o(vi));
  pllc_core uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ref_clk_pin_i(rp), .ref_clk_route_i(rr),
    .user_fb_clk_i(uf), .divider_rst_i(dr), .delay_source_sel_i(sl), .delay_zero_in_i(zi),
    .delay_lag_in_i(li), .delay_value_in_i(vi), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .primary_clk_out_o(po), .shifted_clk_out_o(so),
    .divided_clk_out_o(ko), .lock_o(lock_o), .delay_zero_out_o(zo), .delay_lag_out_o(lo),
    .delay_value_out_o(vo));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // Applies delay controls w, then watches the three clocks for 128 cycles
  task automatic clk_watch(input logic [6:0] w, input int v, input logic lag);
    logic [15:0] p_hist;
    logic [15:0] s_hist;
    logic k_last;
    int rises;
    p_hist = 16'h0000;
    s_hist = 16'h0000;
    k_last = 1'b0;
    rises = -1;
    @(posedge clock_i);
    want <= w;
    repeat (4) @(posedge clock_i);
    for (int n = 0; n < 128; n++)
    begin
      @(posedge clock_i);
      #1;
      p_hist = {p_hist[14:0], po};
      s_hist = {s_hist[14:0], so};
      if (n >= 16)
      begin
        check({7'h0, po}, {7'h0, !p_hist[8]});
        if (lag)
          check({7'h0, so}, {7'h0, p_hist[v]});
        else
          check({7'h0, s_hist[v]}, {7'h0, po});
      end
      if (n >= 1 && po && !p_hist[1] && rises >= 0)
        rises++;
      if (n >= 1 && ko !== k_last)
      begin
        check({7'h0, po && !p_hist[1]}, 8'h01);
        if (rises >= 0)
          check(8'(rises), 8'h02);
        rises = 0;
      end
      k_last = ko;
    end
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial
  begin
    forever #12.5 clock_i = !clock_i;
  end
  initial
  begin
    #250000;
    n_mismatch++;
    results();
  end
  initial
  begin
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(4'h0);
    check(d, 8'h00);
    rd(4'h2);
    check(d, 8'h00);
    check({7'h0, lock_o}, 8'h00);
    rd(4'h1);
    check(d, 8'h00);
    wr(4'h0, 8'h01);
    rd(4'h0);
    check(d, 8'h01);
    foreach (ROWS[i])
    begin
      @(posedge clock_i);
      want <= {1'b0, ROWS[i][10:5]};
      repeat (3) @(posedge clock_i);
      #1;
      if (ROWS[i][10] && ROWS[i][9])
        check({7'h0, zo}, 8'h01);
      else
        check({3'h0, zo, lo, vo}, {3'h0, ROWS[i][4:0]});
    end
    @(posedge clock_i);
    want <= 7'h00;
    wr(4'h2, 8'h04);
    wr(4'h1, 8'h07);
    #1 check({7'h0, irq_o}, 8'h00);
    @(posedge clock_i);
    want <= 7'h33;
    repeat (3) @(posedge clock_i);
    #1 check({7'h0, irq_o}, 8'h01);
    wr(4'h2, 8'h00);
    #1 check({7'h0, irq_o}, 8'h00);
    wr(4'h1, 8'h04);
    wr(4'h2, 8'h04);
    #1 check({7'h0, irq_o}, 8'h00);
    for (int n = 0; n < 3000 && lock_o !== 1'b1; n++)
      @(posedge clock_i);
    #1 check({7'h0, lock_o}, 8'h01);
    rd(4'h1);
    check(d & 8'h81, 8'h81);
    rd(4'h4);
    check(d, 8'h10);
    clk_watch(7'h2b, 3, 1'b1);
    clk_watch(7'h25, 5, 1'b0);
    clk_watch(7'h33, 0, 1'b1);
    @(posedge clock_i);
    want <= 7'h73;
    repeat (3) @(posedge clock_i);
    #1 check({7'h0, lock_o}, 8'h00);
    rd(4'h1);
    check(d & 8'h82, 8'h02);
    // Pin reference and user feedback for the relock
    wr(4'h0, 8'h04);
    @(posedge clock_i);
    want <= 7'h33;
    for (int n = 0; n < 3000 && lock_o !== 1'b1; n++)
      @(posedge clock_i);
    #1 check({7'h0, lock_o}, 8'h01);
    rd(4'h4);
    check(d, 8'h08);
    rd(4'hf);
    check(d, 8'h00);
    results();
  end
endmodule
`default_nettype wire
